// file: verilog/pmuwk_pkg.sv
// Constants shared by the power unit wake-up control block
package pmuwk_pkg;

  // Register addresses
  localparam logic [7:0] PMUWK_ADDR_CONFIG = 8'hb5;
  localparam logic [7:0] PMUWK_ADDR_FLAGS  = 8'hb6;
  localparam logic [7:0] PMUWK_ADDR_MODE   = 8'hb7;

  // wake_config field positions
  localparam int PMUWK_CF_SLEEP   = 7;
  localparam int PMUWK_CF_SUSPEND = 6;
  localparam int PMUWK_CF_CLEAR   = 5;
  localparam int PMUWK_CF_PIN_FLAG = 4;
  localparam int PMUWK_CF_SRC_HI  = 3;

  // wake_flags_ext field positions
  localparam int PMUWK_FL_BATT  = 2;
  localparam int PMUWK_FL_PULSE = 0;

  // power_unit_mode field positions
  localparam int PMUWK_MD_LFOE   = 7;
  localparam int PMUWK_MD_WAKE_OUT = 6;
  localparam int PMUWK_MD_MON_OFF  = 5;

  // Values after reset
  localparam logic [3:0] PMUWK_SRC_RST   = 4'h0;
  localparam logic [2:0] PMUWK_MODE_RST  = 3'h0;
  localparam logic [7:0] PMUWK_RDATA_RST = 8'h00;

  // Timing
  localparam int CLK_PERIOD_PS       = 5000;
  localparam int PIN_RESET_HOLD_NS   = 15;
  localparam int PIN_RESET_HOLD_CYC  =
    (PIN_RESET_HOLD_NS * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_W              = 12;
  localparam int SETTLE_CYC          = 2;
  localparam int SETTLE_W            = 2;

  typedef enum logic [1:0] {
    PMUWK_ACTIVE,
    PMUWK_SLEEP,
    PMUWK_SUSPEND
  } pmuwk_state_e;

endpackage

// file: verilog/pmuwk_top.sv
// Power unit wake-up control: low power entry, wake flags and mode pins
`timescale 1ns/100ps

module pmuwk_top
  import pmuwk_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Wake event sources and reset source event (one-cycle pulses on clk)
  input  wire logic       lf_osc_fail_evt,
  input  wire logic       alarm_evt,
  input  wire logic       port_match_evt,
  input  wire logic       comparator_zero_rise_evt,
  input  wire logic       battery_monitor_evt,
  input  wire logic       pulse_counter_evt,
  input  wire logic       reset_source_evt,
  // Reset pin, asynchronous
  input  wire logic       reset_pin_n,
  // Low-frequency clock to buffer out
  input  wire logic       lf_clk_in,
  // Power control
  output logic            sys_clk_en,
  output logic            core_regulator_on,
  output logic            lp_osc_force_on,
  output logic            supply_monitor_en,
  output logic            full_por_req,
  // P0.2 buffered clock pin
  output logic            p02_out,
  output logic            p02_oe_n,
  // P0.3 wake-up request pin
  output logic            p03_out,
  output logic            p03_oe_n
);
  import pmuwk_pkg::*;

  pmuwk_state_e       state_q;
  logic [3:0]         src_en_q;
  logic [3:0]         src_flag_q;
  logic               rst_flag_q;
  logic               batt_en_q;
  logic               batt_flag_q;
  logic               pulse_en_q;
  logic               pulse_flag_q;
  logic [2:0]         mode_q;
  logic [7:0]         reg_rdata_q;
  logic [SETTLE_W-1:0] settle_q;
  logic [HOLD_W-1:0]  hold_q;
  logic               pin_sync1_q;
  logic               pin_sync2_q;
  logic               pin_prev_q;
  logic               full_por_q;
  logic               pin_fall;
  logic               wr_cfg;
  logic               wr_fl;
  logic               clear_all;
  logic               any_flag;
  logic               wake;
  logic [3:0]         src_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin synchroniser and edge detect

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_sync1_q <= 1'b1;
      pin_sync2_q <= 1'b1;
      pin_prev_q  <= 1'b1;
    end else begin
      pin_sync1_q <= reset_pin_n;
      pin_sync2_q <= pin_sync1_q;
      pin_prev_q  <= pin_sync2_q;
    end
  end

  assign pin_fall  = pin_prev_q & ~pin_sync2_q;
  assign wr_cfg    = reg_wr && (reg_addr == PMUWK_ADDR_CONFIG);
  assign wr_fl     = reg_wr && (reg_addr == PMUWK_ADDR_FLAGS);
  assign clear_all = wr_cfg && reg_wdata[PMUWK_CF_CLEAR];
  assign src_evt   = {lf_osc_fail_evt, alarm_evt, port_match_evt,
                      comparator_zero_rise_evt};
  assign any_flag  = rst_flag_q | (|src_flag_q) | batt_flag_q
                   | pulse_flag_q;

  // Enabled event or reset pin fall ends low power
  assign wake = pin_fall
              | (|(src_evt & src_en_q))
              | (battery_monitor_evt & batt_en_q)
              | (pulse_counter_evt & pulse_en_q);

  ////////////////////////////////////////////////////////////////////////////
  // Enables: sources rewritten by each config write, so entry carries them along; battery and pulse by each flags write

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_en_q   <= PMUWK_SRC_RST;
      batt_en_q  <= 1'b0;
      pulse_en_q <= 1'b0;
    end else begin
      if (wr_cfg) begin
        src_en_q <= reg_wdata[PMUWK_CF_SRC_HI:0];
      end
      if (wr_fl) begin
        batt_en_q  <= reg_wdata[PMUWK_FL_BATT];
        pulse_en_q <= reg_wdata[PMUWK_FL_PULSE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: an event in the clearing cycle still sets its flag

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_src_flag
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          src_flag_q[gi] <= 1'b0;
        end else if (src_evt[gi]) begin
          src_flag_q[gi] <= 1'b1;
        end else if (clear_all) begin
          src_flag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_flag_q   <= 1'b0;
      batt_flag_q  <= 1'b0;
      pulse_flag_q <= 1'b0;
    end else begin
      if (pin_fall) begin
        rst_flag_q <= 1'b1;
      end else if (clear_all) begin
        rst_flag_q <= 1'b0;
      end
      if (battery_monitor_evt) begin
        batt_flag_q <= 1'b1;
      end else if (clear_all) begin
        batt_flag_q <= 1'b0;
      end
      if (pulse_counter_evt) begin
        pulse_flag_q <= 1'b1;
      end else if (clear_all) begin
        pulse_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low power state

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= PMUWK_ACTIVE;
    end else begin
      unique case (state_q)
        PMUWK_ACTIVE: begin
          // Entry refused while a flag stands or the pin hold runs
          if (wr_cfg && !any_flag && hold_q == '0) begin
            if (reg_wdata[PMUWK_CF_SLEEP]) begin
              state_q <= PMUWK_SLEEP;
            end else if (reg_wdata[PMUWK_CF_SUSPEND]) begin
              state_q <= PMUWK_SUSPEND;
            end
          end
        end
        PMUWK_SLEEP: begin
          if (wake) begin
            state_q <= PMUWK_ACTIVE;
          end
        end
        PMUWK_SUSPEND: begin
          if (wake) begin
            state_q <= PMUWK_ACTIVE;
          end
        end
      endcase
    end
  end

  // Flags are masked while they settle after a suspend wake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle_q <= '0;
    end else if (state_q == PMUWK_SUSPEND && wake) begin
      settle_q <= SETTLE_W'(SETTLE_CYC);
    end else if (settle_q != '0) begin
      settle_q <= settle_q - 1'b1;
    end
  end

  // Pin reset needs the device awake long enough to act
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (pin_fall) begin
      hold_q <= HOLD_W'(PIN_RESET_HOLD_CYC);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode register and supply monitor

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q     <= PMUWK_MODE_RST;
      full_por_q <= 1'b0;
    end else begin
      full_por_q <= reset_source_evt & mode_q[0];
      if (reset_source_evt && mode_q[0]) begin
        mode_q[0] <= 1'b0;
      end else if (reg_wr && reg_addr == PMUWK_ADDR_MODE) begin
        mode_q <= reg_wdata[PMUWK_MD_LFOE:PMUWK_MD_MON_OFF];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= PMUWK_RDATA_RST;
    end else if (reg_rd) begin
      reg_rdata_q <= PMUWK_RDATA_RST;
      unique case (reg_addr)
        PMUWK_ADDR_CONFIG: begin
          if (settle_q == '0) begin
            // Strobe bits stay zero
            reg_rdata_q <= {3'h0, rst_flag_q, src_flag_q};
          end
        end
        PMUWK_ADDR_FLAGS: begin
          if (settle_q == '0) begin
            reg_rdata_q <= {5'h00, batt_flag_q, 1'b0, pulse_flag_q};
          end
        end
        PMUWK_ADDR_MODE: begin
          reg_rdata_q <= {mode_q, 5'h00};
        end
        default: begin
          reg_rdata_q <= PMUWK_RDATA_RST;
        end
      endcase
    end else begin
      reg_rdata_q <= PMUWK_RDATA_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata         = reg_rdata_q;
  assign sys_clk_en        = (state_q == PMUWK_ACTIVE);
  assign core_regulator_on = (state_q != PMUWK_SLEEP);
  assign lp_osc_force_on   = any_flag;
  assign supply_monitor_en = ~mode_q[0];
  assign full_por_req      = full_por_q;
  // Clock is gated by the output enable bit, so the pin stays low while disabled
  assign p02_out           = mode_q[2] & lf_clk_in;
  assign p02_oe_n          = ~mode_q[2];
  // High while asleep, low once awake so that others wake too
  assign p03_out           = (state_q == PMUWK_SLEEP);
  assign p03_oe_n          = ~mode_q[1];

endmodule

// file: tb/pmuwk_assertions.sv
// Port checker for the wake-up control block
`timescale 1ns/100ps
module pmuwk_checker
  import pmuwk_pkg::*;
(
  // Clock, reset and register port
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Event sources
  input wire logic       lf_osc_fail_evt,
  input wire logic       alarm_evt,
  input wire logic       port_match_evt,
  input wire logic       comparator_zero_rise_evt,
  input wire logic       battery_monitor_evt,
  input wire logic       pulse_counter_evt,
  input wire logic       reset_source_evt,
  input wire logic       lf_clk_in,
  // Power control and pins
  input wire logic       sys_clk_en,
  input wire logic       core_regulator_on,
  input wire logic       lp_osc_force_on,
  input wire logic       supply_monitor_en,
  input wire logic       full_por_req,
  input wire logic       p02_out,
  input wire logic       p02_oe_n,
  input wire logic       p03_out,
  input wire logic       p03_oe_n
);
  logic any_evt;
  logic mode_wr;
  assign any_evt = lf_osc_fail_evt | alarm_evt | port_match_evt |
    comparator_zero_rise_evt | battery_monitor_evt | pulse_counter_evt;
  assign mode_wr = reg_wr && reg_addr == PMUWK_ADDR_MODE;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////
  a_entry_block: assert property (
    lp_osc_force_on && sys_clk_en |=> sys_clk_en)
    else $error("low power entered with a flag set");
  a_event_flag: assert property (any_evt |=> lp_osc_force_on)
    else $error("event left no flag");
  a_settle_zero: assert property ($rose(sys_clk_en) &&
    $past(core_regulator_on) && reg_rd && reg_addr != PMUWK_ADDR_MODE
    |=> reg_rdata == 8'h00)
    else $error("read just after suspend wake not zero");
  a_sleep_pin: assert property (p03_out == !core_regulator_on)
    else $error("wake request pin wrong");
  a_lf_buffer: assert property (p02_out == (lf_clk_in && !p02_oe_n))
    else $error("buffered clock pin wrong");
  // A reset with the monitor off overrides a mode write in the same cycle
  a_mode_pins: assert property (mode_wr &&
    !(reset_source_evt && !supply_monitor_en) |=>
    p03_oe_n == !$past(reg_wdata[6]) && p02_oe_n == !$past(reg_wdata[7]))
    else $error("pin enables do not follow mode write");
  a_monitor_off: assert property (mode_wr && reg_wdata[5] &&
    !reset_source_evt |=> !supply_monitor_en)
    else $error("supply monitor not disabled");
  a_por_pulse: assert property (reset_source_evt && !supply_monitor_en
    |=> full_por_req && supply_monitor_en ##1 !full_por_req)
    else $error("full power-on reset pulse wrong");
  a_por_cause: assert property (full_por_req |->
    $past(reset_source_evt) && !$past(supply_monitor_en))
    else $error("spurious full power-on reset");
endmodule

bind pmuwk_top pmuwk_checker u_pmuwk_checker (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .lf_osc_fail_evt, .alarm_evt, .port_match_evt, .comparator_zero_rise_evt,
  .battery_monitor_evt, .pulse_counter_evt, .reset_source_evt, .lf_clk_in,
  .sys_clk_en, .core_regulator_on, .lp_osc_force_on, .supply_monitor_en,
  .full_por_req, .p02_out, .p02_oe_n, .p03_out, .p03_oe_n
);

// file: tb/pmuwk_src_model.sv
// Model of the wake event sources, reset pin and slow clock
`timescale 1ns/100ps
module pmuwk_src_model (
  // Clock and bench commands
  input  wire logic       clk,
  input  wire logic [6:0] fire,
  input  wire logic       pin_low,
  // Event pulses and pins
  output logic      [6:0] evt,
  output logic            reset_pin_n,
  output logic            lf_clk_in
);
  logic [2:0] div_q = 3'h0;
  // Sources fire whether or not they are enabled
  always_ff @(posedge clk) begin
    evt <= fire;
  end
  always_ff @(posedge clk) begin
    div_q <= div_q + 3'h1;
  end
  assign lf_clk_in = div_q[2];
  // Pulled up, so a released pin idles high
  assign reset_pin_n = pin_low ? 1'b0 : 1'b1;
endmodule

// file: tb/tb.sv
// Bench for the wake-up control block
`timescale 1ns/100ps
module tb;
  import pmuwk_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [6:0] fire = 7'h00;
  logic       pin_low = 1'b0;
  logic [7:0] rdata;
  logic [6:0] evt;
  logic       rpin_n, lf_clk, clk_en, reg_on, osc_on, mon_en;
  logic       por_req, p02_o, p02_oen, p03_o, p03_oen;
  int         err_count = 0;
  int         compares = 0;
  always #2.5 clk = ~clk;
  pmuwk_src_model u_pmuwk_src_model (.clk(clk), .fire(fire),
    .pin_low(pin_low), .evt(evt), .reset_pin_n(rpin_n), .lf_clk_in(lf_clk));
  pmuwk_top u_pmuwk_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .lf_osc_fail_evt(evt[3]), .alarm_evt(evt[2]),
    .port_match_evt(evt[1]), .comparator_zero_rise_evt(evt[0]),
    .battery_monitor_evt(evt[5]), .pulse_counter_evt(evt[4]),
    .reset_source_evt(evt[6]), .reset_pin_n(rpin_n), .lf_clk_in(lf_clk),
    .sys_clk_en(clk_en), .core_regulator_on(reg_on),
    .lp_osc_force_on(osc_on), .supply_monitor_en(mon_en),
    .full_por_req(por_req), .p02_out(p02_o), .p02_oe_n(p02_oen),
    .p03_out(p03_o), .p03_oe_n(p03_oen));
  ////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task pulse(input logic [6:0] v);
    @(posedge clk);
    fire <= v;
    @(posedge clk);
    fire <= 7'h00;
  endtask
  // Clock enable, regulator, wake pin level, forced oscillator
  task st(input string n, input logic [3:0] e);
    @(posedge clk);
    #1 chk(n, {4'h0, e}, {4'h0, clk_en, reg_on, p03_o, osc_on});
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(PMUWK_ADDR_MODE, 8'h00, "mode");
    rd(PMUWK_ADDR_FLAGS, 8'h00, "flags");
    st("idle", 4'b1100);
    chk("pin enables", 8'h03, {6'h0, p02_oen, p03_oen});
    wr(PMUWK_ADDR_MODE, 8'hff);
    rd(PMUWK_ADDR_MODE, 8'he0, "mode");
    chk("monitor", 8'h00, {7'h0, mon_en});
    chk("pin enables", 8'h00, {6'h0, p02_oen, p03_oen});
    pulse(7'h40);
    @(posedge clk);
    #1 chk("por", 8'h01, {7'h0, por_req});
    rd(PMUWK_ADDR_MODE, 8'hc0, "mode");
    chk("monitor", 8'h01, {7'h0, mon_en});
    chk("por", 8'h00, {7'h0, por_req});
    wr(PMUWK_ADDR_FLAGS, 8'hff);
    rd(PMUWK_ADDR_FLAGS, 8'h00, "flags");
    wr(PMUWK_ADDR_CONFIG, 8'h1f);
    rd(PMUWK_ADDR_CONFIG, 8'h00, "config");
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      pulse(7'h01 << i);
      rd(PMUWK_ADDR_CONFIG, (i < 4) ? 8'h01 << i : 8'h00, "config");
      rd(PMUWK_ADDR_FLAGS, {5'h0, i == 5, 1'b0, i == 4}, "flags");
      wr(PMUWK_ADDR_CONFIG, 8'h20);
      rd(PMUWK_ADDR_FLAGS, 8'h00, "cleared");
    end
    $display("test flags done");
    pulse(7'h01);
    wr(PMUWK_ADDR_CONFIG, 8'h80);
    st("blocked", 4'b1101);
    wr(PMUWK_ADDR_CONFIG, 8'h20);
    wr(PMUWK_ADDR_CONFIG, 8'h81);
    st("sleep", 4'b0010);
    pulse(7'h02);
    st("not enabled", 4'b0011);
    pulse(7'h01);
    st("woke", 4'b1101);
    rd(PMUWK_ADDR_CONFIG, 8'h03, "config");
    wr(PMUWK_ADDR_CONFIG, 8'h20);
    $display("test sleep done");
    for (int j = 0; j < 2; j++) begin
      wr(PMUWK_ADDR_FLAGS, j ? 8'h01 : 8'h04);
      wr(PMUWK_ADDR_CONFIG, 8'h40);
      st("suspend", 4'b0100);
      pulse(j ? 7'h10 : 7'h20);
      rd(PMUWK_ADDR_FLAGS, 8'h00, "settle");
      rd(PMUWK_ADDR_FLAGS, j ? 8'h01 : 8'h04, "flags");
      wr(PMUWK_ADDR_CONFIG, 8'h20);
    end
    $display("test suspend done");
    wr(PMUWK_ADDR_CONFIG, 8'h80);
    pin_low <= 1'b1;
    repeat (4) @(posedge clk);
    pin_low <= 1'b0;
    st("pin wake", 4'b1101);
    rd(PMUWK_ADDR_CONFIG, 8'h10, "config");
    wr(PMUWK_ADDR_CONFIG, 8'h20);
    wr(PMUWK_ADDR_CONFIG, 8'h80);
    st("pin hold", 4'b1100);
    $display("test pin done");
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    wrap_up;
  end
endmodule
